// >>> hdl/rpb_ctl.sv
// processor-side controller: axi4-lite orders turned into patch unit accesses
// Operation
// - slot enable bit gates match detection
// - hit flag set on detected match
// - hit flags at bits 0,2, never software-set
// - compare fetch continuously, request and flag together
// - redirect forces flow to F7FDH
// - software places absolute branch at F7FDH
// - software loads code, addresses, then enables
// - judgment routine test-and-clears flags
// - correction address is an opcode start
// - change address only while slot disabled
// - avoid address right after enabling write
// - no address within 0000H to 007FH
// - no address N+1 or N+2 after flow-end
// - never load F7FDH as correction address
// - patch code only in expansion ram
// - 16-bit address slots, reset 0000H
// - control register, upper bits zero, reset 00H
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rpb_ctl (
  input  wire logic                      CLK,     // system clock
  input  wire logic                      RST,     // synchronous reset, active high
  input  wire logic [rpb_pkg::AXI_AW-1:0] AWADDR, // write address
  input  wire logic                      AWVALID, // write address valid
  output var  logic                      AWREADY, // write address ready
  input  wire logic [31:0]               WDATA,   // write data
  input  wire logic [3:0]                WSTRB,   // write strobes, full words only
  input  wire logic                      WVALID,  // write data valid
  output var  logic                      WREADY,  // write data ready
  output var  logic [1:0]                BRESP,   // write response, always okay
  output var  logic                      BVALID,  // write response valid
  input  wire logic                      BREADY,  // write response ready
  input  wire logic [rpb_pkg::AXI_AW-1:0] ARADDR, // read address
  input  wire logic                      ARVALID, // read address valid
  output var  logic                      ARREADY, // read address ready
  output var  logic [31:0]               RDATA,   // read data
  output var  logic [1:0]                RRESP,   // read response, always okay
  output var  logic                      RVALID,  // read data valid
  input  wire logic                      RREADY,  // read data ready
  output var  logic                      IRQ,     // level interrupt
  rpb_if.ctl                             bus      // patch unit side
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_CAPT  = 4'b0100,
    ST_BTCW  = 4'b1000
  } rpb_ctl_st_t;

  typedef struct packed {
    rpb_ctl_st_t                st;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic                       aw_got;
    logic                       w_got;
    logic [rpb_pkg::AXI_AW-1:0] aw_addr;
    logic [31:0]                w_data;
    logic [31:0]                cmd;
    logic [15:0]                wdat;
    logic [15:0]                rdat;
    logic [15:0]                pc;
    logic                       redir;
    logic                       test;
    logic [1:0]                 en_shadow;
    logic [rpb_pkg::EV_W-1:0]   int_st;
    logic [rpb_pkg::EV_W-1:0]   int_mask;
    logic                       irq;
    logic [15:0]                mem_addr;
    logic [15:0]                mem_wdata;
    logic                       mem_wr;
    logic                       mem_rd;
    logic                       mem_word;
    logic [15:0]                fetch_addr;
    logic                       fetch_valid;
  } rpb_ctl_state_t;

  rpb_ctl_state_t s_reg;
  rpb_ctl_state_t s_next;

  // a value that must never land in a correction slot
  function automatic logic addr_forbidden(input logic [15:0] a);
    addr_forbidden = (a <= rpb_pkg::TABLE_LAST) || (a == rpb_pkg::REDIRECT_TARGET);
  endfunction

  function automatic logic [31:0] read_reg(input logic [rpb_pkg::AXI_AW-1:0] a,
                                           input rpb_ctl_state_t s);
    read_reg = 32'h0000_0000;
    case (a)
      rpb_pkg::OFS_CMD:      read_reg = s.cmd;
      rpb_pkg::OFS_WDATA:    read_reg = {16'h0000, s.wdat};
      rpb_pkg::OFS_STATUS:   read_reg = {13'h0, s.test, s.redir, s.st != ST_IDLE, s.rdat};
      rpb_pkg::OFS_PC:       read_reg = {16'h0000, s.pc};
      rpb_pkg::OFS_INT_ST:   read_reg = {29'h0, s.int_st};
      rpb_pkg::OFS_INT_MASK: read_reg = {29'h0, s.int_mask};
      default:               read_reg = 32'h0000_0000;
    endcase
  endfunction

  logic [rpb_pkg::EV_W-1:0] ev;
  logic                     start;
  logic [15:0]              ctl_wr;

  always_comb begin
    s_next          = s_reg;
    ev              = '0;
    start           = 1'b0;
    ctl_wr          = 16'h0000;
    s_next.mem_wr   = 1'b0;
    s_next.mem_rd   = 1'b0;
    s_next.fetch_valid = 1'b0;

    // read channel
    if (s_reg.rvalid && RREADY) begin
      s_next.rvalid = 1'b0;
    end
    if (ARVALID && s_reg.arready) begin
      s_next.rdata  = read_reg(ARADDR, s_reg);
      s_next.rvalid = 1'b1;
    end
    s_next.arready = !s_next.rvalid;

    // write channel, address and data in either order
    if (s_reg.bvalid && BREADY) begin
      s_next.bvalid = 1'b0;
    end
    if (AWVALID && s_reg.awready) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = AWADDR;
    end
    if (WVALID && s_reg.wready) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = WDATA;
    end
    if (s_next.aw_got && s_next.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      case (s_next.aw_addr)
        rpb_pkg::OFS_CMD: begin
          if (s_reg.st == ST_IDLE) begin
            s_next.cmd = s_next.w_data;
            start      = 1'b1;
          end else begin
            ev[rpb_pkg::EV_REFUSED] = 1'b1;
          end
        end
        rpb_pkg::OFS_WDATA:    s_next.wdat = s_next.w_data[15:0];
        rpb_pkg::OFS_INT_ST:   s_next.int_st = s_reg.int_st & ~s_next.w_data[rpb_pkg::EV_W-1:0];
        rpb_pkg::OFS_INT_MASK: s_next.int_mask = s_next.w_data[rpb_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;

    // launch a patch unit access
    if (start) begin
      s_next.mem_addr   = s_next.cmd[15:0];
      s_next.mem_word   = s_next.cmd[rpb_pkg::CMD_WORD_BIT];
      s_next.fetch_addr = s_next.cmd[15:0];
      ctl_wr            = s_reg.wdat;
      ctl_wr[rpb_pkg::HIT0_BIT] = 1'b0;
      ctl_wr[rpb_pkg::HIT1_BIT] = 1'b0;
      if (s_next.cmd[rpb_pkg::CMD_FETCH_BIT]) begin
        // fetch of an opcode; patch code itself lives where software put it
        s_next.fetch_valid = 1'b1;
        s_next.st          = ST_ISSUE;
      end else if (s_next.cmd[rpb_pkg::CMD_BTC_BIT]) begin
        s_next.mem_addr = rpb_pkg::ADDR_CONTROL;
        s_next.mem_word = 1'b0;
        s_next.mem_rd   = 1'b1;
        s_next.st       = ST_ISSUE;
      end else if (s_next.cmd[rpb_pkg::CMD_WRITE_BIT]) begin
        if ((s_next.cmd[15:0] == rpb_pkg::ADDR_SLOT0 && (s_reg.en_shadow[0]
             || addr_forbidden(s_reg.wdat))) ||
            (s_next.cmd[15:0] == rpb_pkg::ADDR_SLOT1 && (s_reg.en_shadow[1]
             || addr_forbidden(s_reg.wdat)))) begin
          ev[rpb_pkg::EV_REFUSED] = 1'b1;
        end else begin
          s_next.mem_wr = 1'b1;
          s_next.st     = ST_ISSUE;
          if (s_next.cmd[15:0] == rpb_pkg::ADDR_CONTROL) begin
            s_next.mem_wdata = ctl_wr;
            s_next.en_shadow = {ctl_wr[rpb_pkg::EN1_BIT], ctl_wr[rpb_pkg::EN0_BIT]};
          end else begin
            s_next.mem_wdata = s_reg.wdat;
          end
        end
      end else begin
        s_next.mem_rd = 1'b1;
        s_next.st     = ST_ISSUE;
      end
    end

    case (s_reg.st)
      ST_IDLE: ;
      ST_ISSUE: begin
        // device answers one cycle after the strobe
        if (s_reg.cmd[rpb_pkg::CMD_WRITE_BIT] && !s_reg.cmd[rpb_pkg::CMD_FETCH_BIT]
            && !s_reg.cmd[rpb_pkg::CMD_BTC_BIT]) begin
          ev[rpb_pkg::EV_DONE] = 1'b1;
          s_next.st            = ST_IDLE;
        end else begin
          s_next.st = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (s_reg.cmd[rpb_pkg::CMD_FETCH_BIT]) begin
          s_next.redir = bus.redirect_req;
          // after a redirect the next fetch is the branch software placed there
          s_next.pc    = bus.redirect_req ? bus.redirect_target : s_reg.fetch_addr;
          ev[rpb_pkg::EV_REDIR] = bus.redirect_req;
          ev[rpb_pkg::EV_DONE]  = 1'b1;
          s_next.st             = ST_IDLE;
        end else if (s_reg.cmd[rpb_pkg::CMD_BTC_BIT]) begin
          s_next.rdat = bus.mem_rdata;
          s_next.test = s_reg.cmd[rpb_pkg::CMD_SEL_BIT] ? bus.mem_rdata[rpb_pkg::HIT1_BIT]
                                                        : bus.mem_rdata[rpb_pkg::HIT0_BIT];
          // write back with only the tested flag at zero; the other keeps its value
          s_next.mem_wdata = bus.mem_rdata;
          if (s_reg.cmd[rpb_pkg::CMD_SEL_BIT]) begin
            s_next.mem_wdata[rpb_pkg::HIT1_BIT] = 1'b0;
          end else begin
            s_next.mem_wdata[rpb_pkg::HIT0_BIT] = 1'b0;
          end
          s_next.mem_wr = 1'b1;
          s_next.st     = ST_BTCW;
        end else begin
          s_next.rdat          = bus.mem_rdata;
          ev[rpb_pkg::EV_DONE] = 1'b1;
          s_next.st            = ST_IDLE;
        end
      end
      ST_BTCW: begin
        ev[rpb_pkg::EV_DONE] = 1'b1;
        s_next.st            = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase

    // an event in the clearing cycle survives
    s_next.int_st = s_next.int_st | ev;
    s_next.irq    = |(s_next.int_st & s_next.int_mask);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_reg          <= '0;
      s_reg.st       <= ST_IDLE;
      s_reg.awready  <= 1'b1;
      s_reg.wready   <= 1'b1;
      s_reg.arready  <= 1'b1;
      s_reg.int_st   <= rpb_pkg::INT_RST;
      s_reg.int_mask <= rpb_pkg::INT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign AWREADY         = s_reg.awready;
  assign WREADY          = s_reg.wready;
  assign BRESP           = 2'b00;
  assign BVALID          = s_reg.bvalid;
  assign ARREADY         = s_reg.arready;
  assign RDATA           = s_reg.rdata;
  assign RRESP           = 2'b00;
  assign RVALID          = s_reg.rvalid;
  assign IRQ             = s_reg.irq;
  assign bus.mem_addr    = s_reg.mem_addr;
  assign bus.mem_wdata   = s_reg.mem_wdata;
  assign bus.mem_wr      = s_reg.mem_wr;
  assign bus.mem_rd      = s_reg.mem_rd;
  assign bus.mem_word    = s_reg.mem_word;
  assign bus.fetch_addr  = s_reg.fetch_addr;
  assign bus.fetch_valid = s_reg.fetch_valid;
endmodule
`default_nettype wire

// >>> hdl/rpb_dev.sv
// patch unit: correction address slots, comparator and redirect request
`timescale 1ns/1ps
`default_nettype none
module rpb_dev (
  input  wire logic       CLK,     // system clock
  input  wire logic       RST,     // synchronous reset, active high
  rpb_if.dev              bus,     // processor side
  output var  logic [1:0] ENABLES, // slot enables as seen by the comparator
  output var  logic [1:0] HITS     // slot hit flags
);
  typedef struct packed {
    logic [15:0] addr0;
    logic [15:0] addr1;
    logic [1:0]  en;
    logic [1:0]  hit;
    logic [15:0] rdata;
    logic        redirect;
    logic [15:0] target;
  } rpb_dev_state_t;

  rpb_dev_state_t s_reg;
  rpb_dev_state_t s_next;

  function automatic logic [7:0] ctrl_byte(input logic [1:0] en, input logic [1:0] hit);
    ctrl_byte = {4'h0, en[1], hit[1], en[0], hit[0]};
  endfunction

  always_comb begin
    s_next          = s_reg;
    s_next.redirect = 1'b0;
    s_next.target   = 16'h0000;
    if (bus.mem_rd) begin
      case (bus.mem_addr)
        rpb_pkg::ADDR_SLOT0:   s_next.rdata = s_reg.addr0;
        rpb_pkg::ADDR_SLOT1:   s_next.rdata = s_reg.addr1;
        rpb_pkg::ADDR_CONTROL: s_next.rdata = {8'h00, ctrl_byte(s_reg.en, s_reg.hit)};
        default:               s_next.rdata = 16'h0000;
      endcase
    end
    if (bus.mem_wr) begin
      // address slots take word writes only
      if (bus.mem_word && bus.mem_addr == rpb_pkg::ADDR_SLOT0) begin
        s_next.addr0 = bus.mem_wdata;
      end
      if (bus.mem_word && bus.mem_addr == rpb_pkg::ADDR_SLOT1) begin
        s_next.addr1 = bus.mem_wdata;
      end
      if (bus.mem_addr == rpb_pkg::ADDR_CONTROL) begin
        s_next.en[0] = bus.mem_wdata[rpb_pkg::EN0_BIT];
        s_next.en[1] = bus.mem_wdata[rpb_pkg::EN1_BIT];
        // a one written to a hit bit is ignored, a zero clears it
        if (!bus.mem_wdata[rpb_pkg::HIT0_BIT]) begin
          s_next.hit[0] = 1'b0;
        end
        if (!bus.mem_wdata[rpb_pkg::HIT1_BIT]) begin
          s_next.hit[1] = 1'b0;
        end
      end
    end
    // old enable and address are compared, so a new enable acts one cycle late
    if (bus.fetch_valid) begin
      if (s_reg.en[0] && bus.fetch_addr == s_reg.addr0) begin
        s_next.hit[0]   = 1'b1;
        s_next.redirect = 1'b1;
      end
      if (s_reg.en[1] && bus.fetch_addr == s_reg.addr1) begin
        s_next.hit[1]   = 1'b1;
        s_next.redirect = 1'b1;
      end
    end
    if (s_next.redirect) begin
      s_next.target = rpb_pkg::REDIRECT_TARGET;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_reg <= '{addr0: rpb_pkg::ADDR_RST, addr1: rpb_pkg::ADDR_RST,
                 en: {rpb_pkg::CONTROL_RST[rpb_pkg::EN1_BIT],
                      rpb_pkg::CONTROL_RST[rpb_pkg::EN0_BIT]},
                 hit: {rpb_pkg::CONTROL_RST[rpb_pkg::HIT1_BIT],
                       rpb_pkg::CONTROL_RST[rpb_pkg::HIT0_BIT]},
                 rdata: 16'h0000, redirect: 1'b0, target: 16'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.mem_rdata       = s_reg.rdata;
  assign bus.redirect_req    = s_reg.redirect;
  assign bus.redirect_target = s_reg.target;
  assign ENABLES             = s_reg.en;
  assign HITS                = s_reg.hit;
endmodule
`default_nettype wire

// >>> include/rpb_if.sv
// link between the patch unit and the processor side
`timescale 1ns/1ps
`default_nettype none
interface rpb_if;
  logic [15:0] mem_addr;        // data access address
  logic [15:0] mem_wdata;       // write data
  logic        mem_wr;          // write strobe
  logic        mem_rd;          // read strobe
  logic        mem_word;        // 16-bit access
  logic [15:0] mem_rdata;       // read data, one cycle after mem_rd
  logic [15:0] fetch_addr;      // opcode fetch address
  logic        fetch_valid;     // opcode fetch strobe
  logic        redirect_req;    // forced branch request
  logic [15:0] redirect_target; // forced branch target

  modport dev (
    input  mem_addr, mem_wdata, mem_wr, mem_rd, mem_word, fetch_addr, fetch_valid,
    output mem_rdata, redirect_req, redirect_target
  );
  modport ctl (
    output mem_addr, mem_wdata, mem_wr, mem_rd, mem_word, fetch_addr, fetch_valid,
    input  mem_rdata, redirect_req, redirect_target
  );
endinterface
`default_nettype wire

// >>> include/rpb_pkg.sv
// shared constants for the program patch branch unit
`default_nettype none
package rpb_pkg;
  // device register map on the processor data bus
  localparam logic [15:0] ADDR_SLOT0      = 16'hff38;
  localparam logic [15:0] ADDR_SLOT1      = 16'hff3a;
  localparam logic [15:0] ADDR_CONTROL    = 16'hff8a;
  localparam logic [15:0] ADDR_RST        = 16'h0000;
  localparam logic [7:0]  CONTROL_RST     = 8'h00;
  // patch_control field positions
  localparam int          HIT0_BIT        = 0;
  localparam int          EN0_BIT         = 1;
  localparam int          HIT1_BIT        = 2;
  localparam int          EN1_BIT         = 3;
  // fixed redirect target in expansion ram
  localparam logic [15:0] REDIRECT_TARGET = 16'hf7fd;
  // forbidden correction address window (vectors and call table)
  localparam logic [15:0] TABLE_LAST      = 16'h007f;
  // controller register map (axi4-lite byte offsets)
  localparam int          AXI_AW          = 8;
  localparam logic [7:0]  OFS_CMD         = 8'h00;
  localparam logic [7:0]  OFS_WDATA       = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_PC          = 8'h0c;
  localparam logic [7:0]  OFS_INT_ST      = 8'h10;
  localparam logic [7:0]  OFS_INT_MASK    = 8'h14;
  // command word fields
  localparam int          CMD_WRITE_BIT   = 16;
  localparam int          CMD_WORD_BIT    = 17;
  localparam int          CMD_FETCH_BIT   = 18;
  localparam int          CMD_BTC_BIT     = 19;
  localparam int          CMD_SEL_BIT     = 20;
  // status word fields
  localparam int          ST_BUSY_BIT     = 16;
  localparam int          ST_REDIR_BIT    = 17;
  localparam int          ST_TEST_BIT     = 18;
  // interrupt event bits
  localparam int          EV_DONE         = 0;
  localparam int          EV_REDIR        = 1;
  localparam int          EV_REFUSED      = 2;
  localparam int          EV_W            = 3;
  localparam logic [2:0]  INT_RST         = 3'h0;
endpackage
`default_nettype wire

// >>> tb/rom_patch_branch_unit_bench.sv
// bench: axi4-lite orders through the controller into the patch unit
`timescale 1ns/1ps
`default_nettype none
module rom_patch_branch_unit_bench;
  // command flags {sel, test-clear, fetch, word, write}
  localparam logic [4:0] f_ww = 5'h03, f_bw = 5'h01, f_wr = 5'h02, f_br = 5'h00;
  localparam logic [4:0] f_fe = 5'h04, f_t0 = 5'h08, f_t1 = 5'h18;
  localparam logic [15:0] ca = rpb_pkg::ADDR_CONTROL, s0 = rpb_pkg::ADDR_SLOT0;
  localparam logic [15:0] s1 = rpb_pkg::ADDR_SLOT1;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, st;
  logic        awr, wrdy, bv, arr, rv, irq;
  logic [1:0]  bre, rre, en, hit;
  int          errors = 0, compares = 0;
  rpb_if link ();
  rpb_ctl u_rpb_ctl (.CLK(clk), .RST(rst), .AWADDR(awa), .AWVALID(awv), .AWREADY(awr),
    .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrdy), .BRESP(bre), .BVALID(bv),
    .BREADY(1'b1), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdat),
    .RRESP(rre), .RVALID(rv), .RREADY(1'b1), .IRQ(irq), .bus(link));
  rpb_dev u_rpb_dev (.CLK(clk), .RST(rst), .bus(link), .ENABLES(en), .HITS(hit));
  rpb_props u_rpb_props (.CLK(clk), .RST(rst), .mem_addr(link.mem_addr),
    .mem_wdata(link.mem_wdata), .mem_wr(link.mem_wr), .mem_word(link.mem_word),
    .fetch_addr(link.fetch_addr), .fetch_valid(link.fetch_valid),
    .redirect_req(link.redirect_req), .redirect_target(link.redirect_target),
    .ENABLES(en), .HITS(hit));
  always #5 clk = ~clk;
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 100) begin
      errors++;
      $display("wrong value at %0t: no answer", $time);
      conclude();
    end
  endtask
  // bready and rready stay high, so every response is taken at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv && n < 100);
    hang(n);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 100);
    d = rdat;
    hang(n);
  endtask
  task automatic op(input logic [15:0] a, input logic [4:0] f, input logic [15:0] d);
    int n;
    n = 0;
    axi_wr(rpb_pkg::OFS_WDATA, {16'h0000, d});
    axi_wr(rpb_pkg::OFS_CMD, {11'h0, f, a});
    do begin
      axi_rd(rpb_pkg::OFS_STATUS, st);
      n++;
    end while (st[rpb_pkg::ST_BUSY_BIT] !== 1'b0 && n < 100);
    hang(n);
  endtask
  task automatic cread(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    axi_rd(a, v);
    check(v & m, e);
  endtask
  task automatic dread(input logic [15:0] a, input logic [4:0] f, input logic [15:0] e);
    op(a, f, 16'h0000);
    check({16'h0000, st[15:0]}, {16'h0000, e});
  endtask
  task automatic fetch(input logic [15:0] a, input logic [15:0] e);
    op(a, f_fe, 16'h0000);
    cread(rpb_pkg::OFS_PC, 32'h0000ffff, {16'h0000, e});
  endtask
  task automatic tclr(input logic [4:0] f, input logic e);
    op(ca, f, 16'h0000);
    check({31'h0, st[rpb_pkg::ST_TEST_BIT]}, {31'h0, e});
  endtask
  task automatic refuse(input logic [15:0] a, input logic [15:0] d, input logic [15:0] k);
    axi_wr(rpb_pkg::OFS_INT_ST, 32'h7);
    op(a, f_ww, d);
    cread(rpb_pkg::OFS_INT_ST, 32'h4, 32'h4);
    dread(a, f_wr, k);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    dread(s0, f_wr, 16'h0000);
    dread(s1, f_wr, 16'h0000);
    dread(ca, f_br, 16'h0000);
    cread(8'h40, 32'hffffffff, 32'h0);
    op(s0, f_ww, 16'h1000);
    op(s1, f_ww, 16'h2000);
    dread(s1, f_wr, 16'h2000);
    fetch(16'h1000, 16'h1000);
    op(ca, f_bw, 16'h00ff);
    dread(ca, f_br, 16'h000a);
    fetch(16'h0ffe, 16'h0ffe);
    fetch(16'h1000, 16'hf7fd);
    dread(ca, f_br, 16'h000b);
    fetch(16'h2000, 16'hf7fd);
    fetch(16'h1000, 16'hf7fd);
    dread(ca, f_br, 16'h000f);
    tclr(f_t1, 1'b1);
    dread(ca, f_br, 16'h000b);
    tclr(f_t1, 1'b0);
    tclr(f_t0, 1'b1);
    dread(ca, f_br, 16'h000a);
    refuse(s0, 16'h3000, 16'h1000);
    op(ca, f_bw, 16'h0000);
    op(s0, f_bw, 16'h5555);
    dread(s0, f_wr, 16'h1000);
    refuse(s1, 16'h0000, 16'h2000);
    refuse(s1, 16'h007f, 16'h2000);
    refuse(s1, 16'hf7fd, 16'h2000);
    op(s1, f_ww, 16'h0080);
    dread(s1, f_wr, 16'h0080);
    op(ca, f_bw, 16'h0002);
    axi_wr(rpb_pkg::OFS_INT_MASK, 32'h0);
    axi_wr(rpb_pkg::OFS_INT_ST, 32'h7);
    fetch(16'h1000, 16'hf7fd);
    cread(rpb_pkg::OFS_INT_ST, 32'h7, 32'h3);
    irq_is(1'b0);
    axi_wr(rpb_pkg::OFS_INT_MASK, 32'h2);
    irq_is(1'b1);
    axi_wr(rpb_pkg::OFS_INT_ST, 32'h2);
    irq_is(1'b0);
    cread(rpb_pkg::OFS_INT_ST, 32'h7, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    irq_is(1'b0);
    dread(ca, f_br, 16'h0000);
    dread(s0, f_wr, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire

// >>> tb/rpb_props.sv
// concurrent checks on the link between controller and patch unit
`timescale 1ns/1ps
`default_nettype none
module rpb_props (
  input wire logic        CLK,             // clock
  input wire logic        RST,             // sync reset
  input wire logic [15:0] mem_addr,        // access address
  input wire logic [15:0] mem_wdata,       // write data
  input wire logic        mem_wr,          // write strobe
  input wire logic        mem_word,        // 16-bit access
  input wire logic [15:0] fetch_addr,      // fetch address
  input wire logic        fetch_valid,     // fetch strobe
  input wire logic        redirect_req,    // branch request
  input wire logic [15:0] redirect_target, // branch target
  input wire logic [1:0]  ENABLES,         // slot enables
  input wire logic [1:0]  HITS             // hit flags
);
  logic [15:0] a0_reg;
  logic [15:0] a1_reg;
  logic [1:0]  en_reg;
  logic        cw;
  logic        m0;
  logic        m1;
  assign cw = mem_wr && mem_addr == rpb_pkg::ADDR_CONTROL;
  assign m0 = fetch_valid && ENABLES[0] && fetch_addr == a0_reg;
  assign m1 = fetch_valid && ENABLES[1] && fetch_addr == a1_reg;
  // shadow fed only from the link, so a stuck slot register shows up
  always_ff @(posedge CLK) begin
    if (RST) begin
      a0_reg <= rpb_pkg::ADDR_RST;
      a1_reg <= rpb_pkg::ADDR_RST;
      en_reg <= 2'h0;
    end else begin
      if (mem_wr && mem_word && mem_addr == rpb_pkg::ADDR_SLOT0) a0_reg <= mem_wdata;
      if (mem_wr && mem_word && mem_addr == rpb_pkg::ADDR_SLOT1) a1_reg <= mem_wdata;
      if (cw) en_reg <= {mem_wdata[rpb_pkg::EN1_BIT], mem_wdata[rpb_pkg::EN0_BIT]};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_target_fixed: assert property (redirect_req |-> redirect_target == rpb_pkg::REDIRECT_TARGET)
    else $error("redirect target wrong");
  chk_match_redirects: assert property ((m0 || m1) |=> redirect_req)
    else $error("match gave no redirect");
  chk_redirect_cause: assert property (redirect_req |-> $past(m0 || m1))
    else $error("redirect without enabled match");
  chk_hit_on_match: assert property ((m0 |=> HITS[0]) and (m1 |=> HITS[1]))
    else $error("hit flag not set on match");
  // each flag checked on its own; a rise on a vector only looks at its low bit
  chk_hit_origin: assert property (($rose(HITS[0]) |-> $past(m0)) and ($rose(HITS[1]) |-> $past(m1)))
    else $error("hit flag set without match");
  chk_hit_sticky: assert property (HITS[0] && !cw |=> HITS[0])
    else $error("hit flag lost");
  chk_hit_clear: assert property ((cw && !mem_wdata[rpb_pkg::HIT0_BIT] && !m0 |=> !HITS[0]) and
    (cw && !mem_wdata[rpb_pkg::HIT1_BIT] && !m1 |=> !HITS[1]))
    else $error("hit flag not cleared");
  chk_enable_load: assert property (cw |=> ENABLES == en_reg)
    else $error("enables not loaded");
  chk_enable_hold: assert property (!cw |=> $stable(ENABLES))
    else $error("enables changed");
  cov_slot0: cover property (m0 ##1 redirect_req);
  cov_slot1: cover property (m1 ##1 redirect_req);
  cov_clear: cover property ($fell(HITS[1]));
endmodule
`default_nettype wire
